// [rtl/gq_pkg.sv]
// package of constants for the pin readback query block
package gq_pkg;
    localparam logic [7:0] QUERY_CODE = 8'h23;
    localparam logic [7:0] ANSWER_FLAG = 8'h40;
    localparam logic [7:0] ANSWER_CODE = QUERY_CODE | ANSWER_FLAG;
    localparam int ANSWER_LEN = 4;
    localparam int NUM_PINS = 5;
    localparam logic [7:0] LAST_PIN = 8'h04;
    localparam logic [7:0] LAST_LED = 8'h0C;
    localparam logic [7:0] DUTY_MAX = 8'h64;
    localparam int LVL_BIT = 0;
    localparam int FALL_BIT = 1;
    localparam int RISE_BIT = 2;
    localparam int FUNC_BIT = 3;
    localparam int CLK_HZ = 40_000_000;
    localparam int SAMPLE_HZ = 32;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam logic [7:0] REG_INT_STATUS = 8'h00;
    localparam logic [7:0] REG_INT_MASK = 8'h04;
    localparam logic [7:0] REG_PIN_LEVELS = 8'h08;
    localparam logic [2:0] INT_REFUSED = 3'h1;
    localparam logic [2:0] INT_ANSWER = 3'h2;
    localparam logic [2:0] INT_EDGE = 3'h4;
endpackage : gq_pkg

// [rtl/gq_query.sv]
// pin readback query engine with register port and interrupt
`timescale 1ns/10ps
module gq_query #(
    parameter int SAMPLE_PERIOD = gq_pkg::SAMPLE_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic [4:0] PIN_IN,
    input wire logic [39:0] DUTY_CFG,
    input wire logic [39:0] MODE_CFG,
    input wire logic REQ_VALID,
    input wire logic [7:0] REQ_CODE,
    input wire logic [7:0] REQ_INDEX,
    output logic ANS_VALID,
    output logic ANS_ERROR,
    output logic [7:0] ANS_TYPE,
    output logic [7:0] ANS_LEN,
    output logic [31:0] ANS_DATA,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic IRQ
);
    typedef enum logic [1:0] {
        GQ_IDLE = 2'b01,
        GQ_SEND = 2'b10
    } gq_state_e;

    gq_state_e state;
    gq_state_e next_state;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic tick;
    logic [4:0] level;
    logic [4:0] fell;
    logic [4:0] rose;
    logic [4:0] clear;
    logic [2:0] int_status;
    logic [2:0] int_mask;
    logic [2:0] int_set;
    logic take;
    logic is_pin;
    logic is_led;
    logic [2:0] sel;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;

    if (SAMPLE_PERIOD < 2) begin : g_bad_period
        $error("sample period too short");
    end

    // pins are async, two stages before any reader
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= PIN_IN;
            sync2 <= sync1;
        end
    end

    gq_tick #(
        .PERIOD(SAMPLE_PERIOD)
    ) u_tick (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .tick(tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < gq_pkg::NUM_PINS; gi++) begin : g_pin
            gq_sampler u_smp (
                .clk(CLK_SYS),
                .rst_b(RST_B),
                .pin_sync(sync2[gi]),
                .tick(tick),
                .clear(clear[gi]),
                .level(level[gi]),
                .fell(fell[gi]),
                .rose(rose[gi])
            );
            assign clear[gi] = take && is_pin && (sel == 3'(gi));
        end
    endgenerate

    assign take = (state == GQ_IDLE) && REQ_VALID
        && (REQ_CODE == gq_pkg::QUERY_CODE);
    assign is_pin = REQ_INDEX <= gq_pkg::LAST_PIN;
    assign is_led = !is_pin && (REQ_INDEX <= gq_pkg::LAST_LED);
    assign sel = REQ_INDEX[2:0];

    // answer bytes built combinationally, latched into output flops
    always_comb begin
        byte1 = 8'h00;
        byte2 = 8'h00;
        byte3 = 8'h00;
        if (is_pin) begin
            byte1[gq_pkg::LVL_BIT] = level[sel];
            byte1[gq_pkg::FALL_BIT] = fell[sel];
            byte1[gq_pkg::RISE_BIT] = rose[sel];
            byte2 = DUTY_CFG[8*sel +: 8];
            byte3[2:0] = MODE_CFG[8*sel +: 3];
            byte3[gq_pkg::FUNC_BIT] = MODE_CFG[8*sel+3];
        end
        // led duty/mode are not provided here; stored state is zero
        // byte1 and function bit stay zero for leds
    end

    always_comb begin
        next_state = state;
        case (state)
            GQ_IDLE: begin
                if (take) begin
                    next_state = GQ_SEND;
                end
            end
            GQ_SEND: begin
                next_state = GQ_IDLE;
            end
            default: begin
                next_state = GQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            state <= GQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // one cycle answer pulse a cycle after the request
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            ANS_VALID <= 1'b0;
            ANS_ERROR <= 1'b0;
            ANS_TYPE <= 8'h00;
            ANS_LEN <= 8'h00;
            ANS_DATA <= 32'h0;
        end else if (take) begin
            ANS_VALID <= 1'b1;
            ANS_ERROR <= !(is_pin || is_led);
            ANS_TYPE <= gq_pkg::ANSWER_CODE;
            ANS_LEN <= (is_pin || is_led) ? 8'(gq_pkg::ANSWER_LEN) : 8'h00;
            ANS_DATA <= {byte3, byte2, byte1, REQ_INDEX};
        end else begin
            ANS_VALID <= 1'b0;
            ANS_ERROR <= 1'b0;
        end
    end

    // edge bit is a fresh capture; sticky flags would defeat the clear
    assign int_set = {tick && |(level ^ sync2),
        take && (is_pin || is_led), take && !is_pin && !is_led};

    // set wins over write-one-to-clear
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            int_status <= 3'h0;
        end else if (REG_WR && REG_ADDR == gq_pkg::REG_INT_STATUS) begin
            int_status <= (int_status & ~REG_WDATA[2:0]) | int_set;
        end else begin
            int_status <= int_status | int_set;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            int_mask <= 3'h0;
        end else if (REG_WR && REG_ADDR == gq_pkg::REG_INT_MASK) begin
            int_mask <= REG_WDATA[2:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_status & int_mask);
        end
    end

    // unmapped reads return zero
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            REG_RDATA <= 32'h0;
        end else if (REG_RD) begin
            case (REG_ADDR)
                gq_pkg::REG_INT_STATUS: REG_RDATA <= {29'h0, int_status};
                gq_pkg::REG_INT_MASK: REG_RDATA <= {29'h0, int_mask};
                gq_pkg::REG_PIN_LEVELS: REG_RDATA <= {17'h0, rose, fell, level};
                default: REG_RDATA <= 32'h0;
            endcase
        end else begin
            REG_RDATA <= 32'h0;
        end
    end

    property p_answer_code;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take |=> ANS_VALID && ANS_TYPE == 8'h63;
    endproperty
    a_answer_code: assert property (p_answer_code)
        else $error("answer type wrong");

    property p_echo_index;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take |=> ANS_DATA[7:0] == $past(REQ_INDEX);
    endproperty
    a_echo_index: assert property (p_echo_index)
        else $error("index not echoed");

    property p_led_zero;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && is_led |=> ANS_DATA[15:8] == 8'h00 && !ANS_DATA[27];
    endproperty
    a_led_zero: assert property (p_led_zero)
        else $error("led byte not zero");

    property p_bad_index;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && REQ_INDEX > 8'h0C |=> ANS_ERROR && ANS_LEN == 8'h00;
    endproperty
    a_bad_index: assert property (p_bad_index)
        else $error("bad index not refused");

    property p_good_len;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && REQ_INDEX <= 8'h0C |=> !ANS_ERROR && ANS_LEN == 8'h04;
    endproperty
    a_good_len: assert property (p_good_len)
        else $error("length not four");

    property p_level_held;
        @(posedge CLK_SYS) disable iff (!RST_B)
        !tick |=> $stable(level);
    endproperty
    a_level_held: assert property (p_level_held)
        else $error("level moved without tick");

    property p_clear_edges;
        @(posedge CLK_SYS) disable iff (!RST_B)
        clear[0] && !tick |=> !fell[0] && !rose[0];
    endproperty
    a_clear_edges: assert property (p_clear_edges)
        else $error("edges not restarted");

    property p_pin_level;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && REQ_INDEX == 8'h00 |=> ANS_DATA[8] == $past(level[0]);
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("level bit wrong");

    property p_ans_pulse;
        @(posedge CLK_SYS) disable iff (!RST_B)
        ANS_VALID |=> !ANS_VALID;
    endproperty
    a_ans_pulse: assert property (p_ans_pulse)
        else $error("answer longer than one cycle");

    property p_refused_status;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && !is_pin && !is_led |=> int_status[0];
    endproperty
    a_refused_status: assert property (p_refused_status)
        else $error("refusal not flagged");

    property p_answered_status;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && (is_pin || is_led) |=> int_status[1];
    endproperty
    a_answered_status: assert property (p_answered_status)
        else $error("answer not flagged");

    property p_edge_status;
        @(posedge CLK_SYS) disable iff (!RST_B)
        tick && |(level ^ sync2) |=> int_status[2];
    endproperty
    a_edge_status: assert property (p_edge_status)
        else $error("sampled edge not flagged");

    property p_fall_capture;
        @(posedge CLK_SYS) disable iff (!RST_B)
        tick && level[0] && !sync2[0] |=> fell[0];
    endproperty
    a_fall_capture: assert property (p_fall_capture)
        else $error("falling edge lost");

    property p_rise_capture;
        @(posedge CLK_SYS) disable iff (!RST_B)
        tick && !level[0] && sync2[0] |=> rose[0];
    endproperty
    a_rise_capture: assert property (p_rise_capture)
        else $error("rising edge lost");

    property p_level_follows;
        @(posedge CLK_SYS) disable iff (!RST_B)
        tick |=> level == $past(sync2);
    endproperty
    a_level_follows: assert property (p_level_follows)
        else $error("level not the sensed pin");

    property p_led_cfg;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && is_led |=> ANS_DATA[31:16] == 16'h0000;
    endproperty
    a_led_cfg: assert property (p_led_cfg)
        else $error("led config not zero");

    property p_reserved_zero;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take |=> ANS_DATA[31:28] == 4'h0 && ANS_DATA[15:11] == 5'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    property p_duty_pass;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && REQ_INDEX == 8'h00 |=> ANS_DATA[23:16] == $past(DUTY_CFG[7:0]);
    endproperty
    a_duty_pass: assert property (p_duty_pass)
        else $error("duty byte wrong");

    property p_mode_pass;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && REQ_INDEX == 8'h00 |=> ANS_DATA[26:24] == $past(MODE_CFG[2:0]);
    endproperty
    a_mode_pass: assert property (p_mode_pass)
        else $error("drive mode wrong");

    property p_func_pass;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take && REQ_INDEX == 8'h00 |=> ANS_DATA[27] == $past(MODE_CFG[3]);
    endproperty
    a_func_pass: assert property (p_func_pass)
        else $error("function bit wrong");

    property p_one_take;
        @(posedge CLK_SYS) disable iff (!RST_B)
        take |=> !take;
    endproperty
    a_one_take: assert property (p_one_take)
        else $error("request taken back to back");

    c_edge_clear: cover property (@(posedge CLK_SYS) clear[0] && rose[0]);
    c_pin_query: cover property (@(posedge CLK_SYS) take && is_pin);
    c_led_query: cover property (@(posedge CLK_SYS) take && is_led);
    c_bad_query: cover property (@(posedge CLK_SYS) take && !is_pin && !is_led);
    c_irq: cover property (@(posedge CLK_SYS) IRQ);
endmodule : gq_query

// [rtl/gq_sampler.sv]
// per pin sampler with edge capture
`timescale 1ns/10ps
module gq_sampler (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin_sync,
    input wire logic tick,
    input wire logic clear,
    output logic level,
    output logic fell,
    output logic rose
);
    // only the tick may change the level, so bounce is filtered
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            level <= 1'b0;
        end else if (tick) begin
            level <= pin_sync;
        end
    end
    // a tick edge in the clear cycle survives the clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fell <= 1'b0;
            rose <= 1'b0;
        end else begin
            fell <= (tick && level && !pin_sync) || (fell && !clear);
            rose <= (tick && !level && pin_sync) || (rose && !clear);
        end
    end
endmodule : gq_sampler

// [rtl/gq_tick.sv]
// free running sample tick divider
`timescale 1ns/10ps
module gq_tick #(
    parameter int PERIOD = gq_pkg::SAMPLE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic tick
);
    logic [31:0] count;
    if (PERIOD < 2) begin : g_bad_period
        $error("gq_tick period too short");
    end
    // not tied to query arrival
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count == 32'(PERIOD - 1)) begin
            count <= 32'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : gq_tick

// [testbench/gq_host.sv]
// host model issuing pin readback requests
`timescale 1ns/10ps
module gq_host (
    input wire logic clk,
    output logic req_valid,
    output logic [7:0] req_code,
    output logic [7:0] req_index
);
    initial begin
        req_valid = 1'b0;
        req_code = 8'h00;
        req_index = 8'h00;
    end
    // released lines show the inverse, not the last value
    task automatic send(input logic [7:0] code, input logic [7:0] index);
        @(posedge clk);
        req_valid <= 1'b1;
        req_code <= code;
        req_index <= index;
        @(posedge clk);
        req_valid <= 1'b0;
        req_code <= ~code;
        req_index <= ~index;
    endtask : send
endmodule : gq_host

// [testbench/gq_tb_top.sv]
// self-checking bench for the pin readback query block
`timescale 1ns/10ps
module gpio_level_config_query_tb_top;
    logic clk_sys;
    logic rst_b;
    logic [4:0] pin_in;
    logic [39:0] duty_cfg;
    logic [39:0] mode_cfg;
    logic req_valid;
    logic [7:0] req_code;
    logic [7:0] req_index;
    logic ans_valid;
    logic ans_error;
    logic [7:0] ans_type;
    logic [7:0] ans_len;
    logic [31:0] ans_data;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic irq;
    int err_total;
    int n_compared;

    gq_host i_host (.clk(clk_sys), .req_valid(req_valid),
        .req_code(req_code), .req_index(req_index));
    // short sample period keeps the run brief
    gq_query #(.SAMPLE_PERIOD(8)) i_dut (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .PIN_IN(pin_in), .DUTY_CFG(duty_cfg), .MODE_CFG(mode_cfg),
        .REQ_VALID(req_valid), .REQ_CODE(req_code), .REQ_INDEX(req_index),
        .ANS_VALID(ans_valid), .ANS_ERROR(ans_error), .ANS_TYPE(ans_type),
        .ANS_LEN(ans_len), .ANS_DATA(ans_data), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .IRQ(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t %s", $time, what);
        end
    endtask : chk

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wait_clk

    task automatic ask(input int idx, input logic [7:0] lvl);
        logic [7:0] cfg;
        logic [7:0] duty;
        // settings read after the request, so a fresh write is seen
        i_host.send(8'h23, 8'(idx));
        cfg = 8'h00;
        duty = 8'h00;
        if (idx < 5) begin
            cfg = mode_cfg[8*idx +: 8] & 8'h0F;
            duty = duty_cfg[8*idx +: 8];
        end
        @(negedge clk_sys);
        chk(ans_valid, 1'b1, "answer pulse");
        chk(ans_error, 1'b0, "error flag");
        chk(ans_type, 8'h63, "answer type");
        chk(ans_len, 8'h04, "answer length");
        chk(ans_data, {cfg, duty, lvl, 8'(idx)}, "answer data");
        @(negedge clk_sys);
        chk(ans_valid, 1'b0, "pulse length");
        // end on a rising edge so callers drive inputs there
        @(posedge clk_sys);
    endtask : ask

    task automatic ask_bad(input logic [7:0] code, input logic [7:0] idx,
            input logic err);
        i_host.send(code, idx);
        @(negedge clk_sys);
        chk(ans_valid, err, "refusal pulse");
        chk(ans_error, err, "refusal error");
        if (err) begin
            chk(ans_len, 8'h00, "refusal length");
        end
        @(posedge clk_sys);
    endtask : ask_bad

    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_wr_t

    task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_rd_t

    task automatic t_modes;
        for (int m = 0; m < 16; m++) begin
            @(posedge clk_sys);
            mode_cfg <= {5{4'hF, 4'(m)}};
            ask(m % 5, 8'h00);
        end
        $display("test modes done");
    endtask : t_modes

    task automatic t_edges;
        pin_in <= 5'h01;
        wait_clk(30);
        ask(0, 8'h05);
        ask(0, 8'h01);
        ask(1, 8'h00);
        pin_in <= 5'h00;
        wait_clk(30);
        ask(0, 8'h02);
        pin_in <= 5'h01;
        wait_clk(30);
        pin_in <= 5'h00;
        wait_clk(30);
        ask(0, 8'h06);
        $display("test edges done");
    endtask : t_edges

    task automatic t_leds;
        for (int i = 5; i < 13; i++) ask(i, 8'h00);
        $display("test leds done");
    endtask : t_leds

    task automatic t_bad;
        ask_bad(8'h22, 8'h00, 1'b0);
        ask_bad(8'h23, 8'h0D, 1'b1);
        ask_bad(8'h23, 8'hFF, 1'b1);
        $display("test refusals done");
    endtask : t_bad

    task automatic t_regs;
        logic [31:0] d;
        pin_in <= 5'h1A;
        wait_clk(30);
        reg_rd_t(8'h08, d);
        chk(d[4:0], 5'h1A, "level register");
        reg_rd_t(8'h00, d);
        chk(d[2], 1'b1, "edge status");
        reg_wr_t(8'h04, 32'h0000_0000);
        reg_wr_t(8'h00, 32'h0000_0007);
        reg_rd_t(8'h00, d);
        chk(d, 32'h0000_0000, "status cleared");
        ask_bad(8'h23, 8'h0D, 1'b1);
        ask(0, 8'h00);
        reg_rd_t(8'h00, d);
        chk(d, 32'h0000_0003, "refused and answered status");
        chk(irq, 1'b0, "masked interrupt");
        reg_wr_t(8'h04, 32'h0000_0001);
        wait_clk(2);
        chk(irq, 1'b1, "interrupt raised");
        reg_wr_t(8'h00, 32'h0000_0007);
        wait_clk(2);
        chk(irq, 1'b0, "interrupt cleared");
        reg_rd_t(8'h10, d);
        chk(d, 32'h0000_0000, "unmapped read");
        $display("test registers done");
    endtask : t_regs

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        rst_b = 1'b0;
        pin_in = 5'h00;
        duty_cfg = {8'h64, 8'h4B, 8'h32, 8'h19, 8'h00};
        mode_cfg = 40'h00_0000_0000;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_total = 0;
        n_compared = 0;
        wait_clk(12);
        rst_b <= 1'b1;
        t_modes;
        t_edges;
        t_leds;
        t_bad;
        t_regs;
        conclude;
    end

    // whole run needs well under 2000 cycles
    initial begin
        wait_clk(20000);
        err_total++;
        conclude;
    end
endmodule : gpio_level_config_query_tb_top
